// [hw/gpe_pkg.sv]
// Package: register map, field positions and reset values of the I/O port block
package gpe_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] GPE_PA_DATA_ADDR = 12'h000;
  localparam logic [11:0] GPE_PA_DIR_ADDR = 12'h004;
  localparam logic [11:0] GPE_EDGE_EN_ADDR = 12'h008;
  localparam logic [11:0] GPE_PB_DATA_ADDR = 12'h00C;
  localparam logic [11:0] GPE_PB_DIR_ADDR = 12'h010;
  localparam logic [11:0] GPE_PEND_ADDR = 12'h014;
  localparam logic [11:0] GPE_GMASK_ADDR = 12'h018;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] GPE_EDGE_EN_RST = 8'h00;
  localparam logic [7:0] GPE_DIR_RST = 8'h00;
  localparam logic [7:0] GPE_DATA_RST = 8'h00;
  localparam logic GPE_GMASK_RST = 1'b1;
  // Port A pins without pull-up, open-drain only
  localparam logic [7:0] GPE_PA_OD_MASK = 8'h06;
  localparam logic [7:0] GPE_PA_PULLUP_RST = 8'hF9;
  // Interrupt-capable pins of one port
  localparam logic [7:0] GPE_IRQ_PIN_MASK = 8'hF0;
  // Lines per port: rising on pins 4,5, falling on pins 6,7
  localparam int GPE_RISE_LO = 4;
  localparam int GPE_FALL_LO = 6;
  localparam logic [31:0] GPE_RDATA_ZERO = 32'h0000_0000;
endpackage : gpe_pkg

// [hw/gpe_edge_detect.sv]
// File: synchroniser and edge detector for the interrupt lines of one port
`timescale 1ns/1ps
module gpe_edge_detect
  import gpe_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] pinIn,
  output logic [7:0] pinSync,
  output logic [3:0] edgeSeen
);
  logic [7:0] meta_q;
  logic [7:0] sync_q;
  logic [7:0] prev_q;

  // ----------------------------------------------------------------
  // Two-stage synchroniser, then previous sample
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 8'hFF;
      sync_q <= 8'hFF;
      prev_q <= 8'hFF;
    end else begin
      meta_q <= pinIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign pinSync = sync_q;
  // Pins 4,5 rising; pins 6,7 falling
  assign edgeSeen[1:0] = sync_q[GPE_RISE_LO +: 2] & ~prev_q[GPE_RISE_LO +: 2];
  assign edgeSeen[3:2] = ~sync_q[GPE_FALL_LO +: 2] & prev_q[GPE_FALL_LO +: 2];
endmodule : gpe_edge_detect

// [hw/gpe_port.sv]
// File: two eight-bit I/O ports with edge interrupt lines and APB register access
`timescale 1ns/1ps
//
// Function
// - Eight-bit read/write edge enable register, reset to zero.
// - Bit 7 arms line eight, down to bit 0 arming line one.
// - Lines one, two, five, six fire on rising edges when armed.
// - Lines three, four, seven, eight fire on falling edges when armed.
// - No external interrupt comes from any other pin.
// - Direction bit X sets pin X: 0 input, 1 output; data same mapping.
// - Data read of an input pin returns the pin level.
// - Each interrupt pin raises its own request independently.
// - Requests of one vector group are ORed together.
// - Output pin drives the latch; data read returns the latch.
// - Output-mode pins never generate interrupts.
// - Peripheral claim of a pin overrides direction and data settings.
// - Peripheral drive forces output mode, push-pull or open-drain.
// - Peripheral inputs need input mode; data read still returns pin level.
// - Port A pins 4 to 7 are lines one to four; 4,5 feed captures.
// - Port A pins 1,2 reset without pull-up, open-drain only; others pull-up.
// - Enabled edge interrupts the processor only while global mask clear.
module gpe_port
  import gpe_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] portaIn,
  output logic [7:0] portaOut,
  output logic [7:0] portaOe,
  output logic [7:0] portaPullup,
  input wire logic [7:0] portbIn,
  output logic [7:0] portbOut,
  output logic [7:0] portbOe,
  output logic [7:0] portbPullup,
  input wire logic [7:0] portaAltOutEn,
  input wire logic [7:0] portaAltOut,
  input wire logic [7:0] portaAltOd,
  input wire logic [7:0] portbAltOutEn,
  input wire logic [7:0] portbAltOut,
  input wire logic [7:0] portbAltOd,
  output logic [7:0] portaAltIn,
  output logic [7:0] portbAltIn,
  output logic timerCaptureOne,
  output logic timerCaptureTwo,
  output logic extIrqReq
);
  logic [7:0] extIrqEdgeEnable_q;
  logic [7:0] paData_q;
  logic [7:0] paDir_q;
  logic [7:0] pbData_q;
  logic [7:0] pbDir_q;
  logic [7:0] pend_q;
  logic [7:0] pend_d;
  logic gmask_q;
  logic [7:0] paSync;
  logic [7:0] pbSync;
  logic [3:0] paEdge;
  logic [3:0] pbEdge;
  logic [7:0] lineEdge;
  logic [7:0] lineInput;
  logic [7:0] lineFire;
  logic [7:0] pendClr;
  logic wrEn;
  logic rdEn;
  logic hit;
  logic [31:0] rdMux;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Pin drive: alternate output overrides the latch where its enable is set
  function automatic logic [7:0] pin_value(input logic [7:0] altEn, input logic [7:0] alt,
                                           input logic [7:0] latch);
    pin_value = (altEn & alt) | (~altEn & latch);
  endfunction : pin_value

  // Data read: latch for outputs, pin level for inputs
  function automatic logic [7:0] data_read(input logic [7:0] dir, input logic [7:0] latch,
                                           input logic [7:0] pins);
    data_read = (dir & latch) | (~dir & pins);
  endfunction : data_read

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  gpe_edge_detect uPaEdge (
    .core_clk(core_clk),
    .nrst(nrst),
    .pinIn(portaIn),
    .pinSync(paSync),
    .edgeSeen(paEdge)
  );

  gpe_edge_detect uPbEdge (
    .core_clk(core_clk),
    .nrst(nrst),
    .pinIn(portbIn),
    .pinSync(pbSync),
    .edgeSeen(pbEdge)
  );

  // Line order: bit0 line one .. bit7 line eight
  // Port A pins 4..7 are lines one..four, port B pins 4..7 lines five..eight
  assign lineEdge = {pbEdge, paEdge};
  // A line is live only while its pin is an input without peripheral drive
  assign lineInput = {~pbDir_q[7:4] & ~portbAltOutEn[7:4], ~paDir_q[7:4] & ~portaAltOutEn[7:4]};
  // Only the eight armed lines can fire
  assign lineFire = lineEdge & lineInput & extIrqEdgeEnable_q;

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & ~pwrite;

  always_comb begin
    hit = 1'b1;
    rdMux = GPE_RDATA_ZERO;
    if (paddr == GPE_PA_DATA_ADDR) begin
      rdMux[7:0] = data_read(paDir_q, paData_q, paSync);
    end else if (paddr == GPE_PA_DIR_ADDR) begin
      rdMux[7:0] = paDir_q;
    end else if (paddr == GPE_EDGE_EN_ADDR) begin
      rdMux[7:0] = extIrqEdgeEnable_q;
    end else if (paddr == GPE_PB_DATA_ADDR) begin
      rdMux[7:0] = data_read(pbDir_q, pbData_q, pbSync);
    end else if (paddr == GPE_PB_DIR_ADDR) begin
      rdMux[7:0] = pbDir_q;
    end else if (paddr == GPE_PEND_ADDR) begin
      rdMux[7:0] = pend_q;
    end else if (paddr == GPE_GMASK_ADDR) begin
      rdMux[0] = gmask_q;
    end else begin
      hit = 1'b0;
    end
  end

  assign pslverr = psel & penable & ~hit;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= GPE_RDATA_ZERO;
    end else if (rdEn & ~penable) begin
      prdata <= rdMux;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      extIrqEdgeEnable_q <= GPE_EDGE_EN_RST;
    end else if (wrEn && paddr == GPE_EDGE_EN_ADDR) begin
      extIrqEdgeEnable_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      paData_q <= GPE_DATA_RST;
      paDir_q <= GPE_DIR_RST;
      pbData_q <= GPE_DATA_RST;
      pbDir_q <= GPE_DIR_RST;
    end else if (wrEn) begin
      if (paddr == GPE_PA_DATA_ADDR) begin
        paData_q <= pwdata[7:0];
      end else if (paddr == GPE_PA_DIR_ADDR) begin
        paDir_q <= pwdata[7:0];
      end else if (paddr == GPE_PB_DATA_ADDR) begin
        pbData_q <= pwdata[7:0];
      end else if (paddr == GPE_PB_DIR_ADDR) begin
        pbDir_q <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gmask_q <= GPE_GMASK_RST;
    end else if (wrEn && paddr == GPE_GMASK_ADDR) begin
      gmask_q <= pwdata[0];
    end
  end

  // ----------------------------------------------------------------
  // Pending latches: write 1 clears, new edge wins over clear
  // ----------------------------------------------------------------
  assign pendClr = (wrEn && paddr == GPE_PEND_ADDR) ? pwdata[7:0] : 8'h00;
  assign pend_d = (pend_q & ~pendClr) | lineFire;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pend_q <= 8'h00;
    end else begin
      pend_q <= pend_d;
    end
  end

  // Shared vector: all lines ORed, held pending while masked
  assign extIrqReq = (|pend_q) & ~gmask_q;

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      portaOut <= GPE_DATA_RST;
      portaOe <= GPE_DIR_RST;
      portbOut <= GPE_DATA_RST;
      portbOe <= GPE_DIR_RST;
    end else begin
      // Open-drain pins drive only a low level
      portaOut <= pin_value(portaAltOutEn, portaAltOut, paData_q);
      portaOe <= (portaAltOutEn | paDir_q) & ~((GPE_PA_OD_MASK | (portaAltOd & portaAltOutEn))
                 & pin_value(portaAltOutEn, portaAltOut, paData_q));
      portbOut <= pin_value(portbAltOutEn, portbAltOut, pbData_q);
      portbOe <= (portbAltOutEn | pbDir_q) & ~(portbAltOd & portbAltOutEn
                 & pin_value(portbAltOutEn, portbAltOut, pbData_q));
    end
  end

  // Pull-ups only on inputs with pull-up capability
  assign portaPullup = GPE_PA_PULLUP_RST & ~paDir_q & ~portaAltOutEn;
  assign portbPullup = ~pbDir_q & ~portbAltOutEn;

  // ----------------------------------------------------------------
  // Peripheral inputs
  // ----------------------------------------------------------------
  assign portaAltIn = paSync;
  assign portbAltIn = pbSync;
  assign timerCaptureOne = paSync[4];
  assign timerCaptureTwo = paSync[5];
endmodule : gpe_port

// [test/gpe_port_props.sv]
// Checker: port-level properties of the I/O port block
`timescale 1ns/1ps
module gpe_port_props
  import gpe_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] portaOut,
  input wire logic [7:0] portaOe,
  input wire logic [7:0] portaPullup,
  input wire logic [7:0] portaAltOutEn,
  input wire logic [7:0] portaAltOut,
  input wire logic [7:0] portaAltOd,
  input wire logic [7:0] portaAltIn,
  input wire logic timerCaptureOne,
  input wire logic timerCaptureTwo
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_en_ready: assert property (psel && penable && paddr == GPE_EDGE_EN_ADDR |-> pready && !pslverr)
    else $error("enable access refused");
  a_unmapped_err: assert property (psel && penable && paddr == 12'hFFC |-> pslverr)
    else $error("unmapped access accepted");
  a_upper_zero: assert property (psel && !penable && !pwrite |=> (prdata & 32'hFFFF_FF00) == 32'h0000_0000)
    else $error("upper read bits set");
  a_alt_value: assert property (((portaOut ^ $past(portaAltOut)) & $past(portaAltOutEn & ~portaAltOd)) == 8'h00)
    else $error("pin not from peripheral");
  a_alt_drive: assert property (((portaOe ^ ~$past(portaAltOd & portaAltOut)) & $past(portaAltOutEn)) == 8'h00)
    else $error("peripheral drive mode wrong");
  a_pullup_off: assert property (portaPullup[2:1] == 2'b00)
    else $error("pull-up on open-drain pin");
  a_od_only: assert property ((portaOe & portaOut & GPE_PA_OD_MASK) == 8'h00)
    else $error("open-drain pin drives high");
  a_capture_tap: assert property (timerCaptureOne == portaAltIn[4] && timerCaptureTwo == portaAltIn[5])
    else $error("capture tap differs from pin");
endmodule : gpe_port_props

// [test/gpe_board.sv]
// Board model: pin level seen by the block, from its own drive or the board's
`timescale 1ns/1ps
module gpe_board (
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] drive,
  output logic [7:0] pinLevel
);
  // Block driver wins where enabled, the board drives every other pin
  assign pinLevel = (pinOe & pinOut) | (~pinOe & drive);
endmodule : gpe_board

// [test/tb_gpe_port.sv]
// Testbench: register, pin and edge interrupt scenarios for the I/O port block
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_gpe_port
  import gpe_pkg::*;
;
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, extIrqReq, timerCaptureOne, timerCaptureTwo, errv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [7:0] portaIn, portaOut, portaOe, portaPullup, portaAltOutEn, portaAltOut, portaAltOd, portaAltIn;
  logic [7:0] portbIn, portbOut, portbOe, portbPullup, portbAltOutEn, portbAltOut, portbAltOd, portbAltIn;
  logic [7:0] boardA, boardB;
  int fails, n_checks;
  gpe_port i_gpe_port (
    .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .portaIn(portaIn), .portaOut(portaOut), .portaOe(portaOe), .portaPullup(portaPullup),
    .portbIn(portbIn), .portbOut(portbOut), .portbOe(portbOe), .portbPullup(portbPullup),
    .portaAltOutEn(portaAltOutEn), .portaAltOut(portaAltOut), .portaAltOd(portaAltOd),
    .portbAltOutEn(portbAltOutEn), .portbAltOut(portbAltOut), .portbAltOd(portbAltOd),
    .portaAltIn(portaAltIn), .portbAltIn(portbAltIn),
    .timerCaptureOne(timerCaptureOne), .timerCaptureTwo(timerCaptureTwo), .extIrqReq(extIrqReq)
  );
  gpe_board i_gpe_board_a (.pinOut(portaOut), .pinOe(portaOe), .drive(boardA), .pinLevel(portaIn));
  gpe_board i_gpe_board_b (.pinOut(portbOut), .pinOe(portbOe), .drive(boardB), .pinLevel(portbIn));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // Wait for the slave; only the watchdog ends a hung transfer
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic sw(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : sw
  task automatic pins(input logic [7:0] a, input logic [7:0] b);
    @(posedge core_clk);
    boardA <= a;
    boardB <= b;
  endtask : pins
  task automatic t_reset();
    sw(0);
    `CHK({portaPullup, portbPullup, portaOe}, {8'hF9, 8'hFF, 8'h00})
    bus(1'b0, GPE_EDGE_EN_ADDR, 32'h0);
    `CHK(rdv, 32'h0000_0000)
    bus(1'b1, GPE_EDGE_EN_ADDR, 32'hFFFF_FF5A);
    bus(1'b0, GPE_EDGE_EN_ADDR, 32'h0);
    `CHK(rdv, 32'h0000_005A)
    bus(1'b0, 12'hFFC, 32'h0);
    `CHK({errv, rdv}, {1'b1, 32'h0000_0000})
  endtask : t_reset
  task automatic t_mask();
    bus(1'b1, GPE_EDGE_EN_ADDR, 32'h0000_0001);
    pins(8'hD0, 8'hC0);
    sw(6);
    `CHK(extIrqReq, 1'b0)
    bus(1'b0, GPE_PEND_ADDR, 32'h0);
    `CHK(rdv, 32'h0000_0001)
    bus(1'b1, GPE_GMASK_ADDR, 32'h0);
    sw(1);
    `CHK(extIrqReq, 1'b1)
    pins(8'hC0, 8'hC0);
    bus(1'b1, GPE_PEND_ADDR, 32'h0000_00FF);
  endtask : t_mask
  task automatic t_edges();
    logic [7:0] act;
    for (int i = 0; i < 8; i++) begin
      act = 8'hC0 ^ (8'h10 << (i % 4));
      bus(1'b1, GPE_EDGE_EN_ADDR, 32'(1 << i));
      pins(i < 4 ? act : 8'hC0, i < 4 ? 8'hC0 : act);
      sw(6);
      `CHK(extIrqReq, 1'b1)
      bus(1'b0, GPE_PEND_ADDR, 32'h0);
      `CHK(rdv, 32'(1 << i))
      bus(1'b1, GPE_PEND_ADDR, 32'h0000_00FF);
      pins(8'hC0, 8'hC0);
      sw(6);
      `CHK(extIrqReq, 1'b0)
    end
    bus(1'b1, GPE_EDGE_EN_ADDR, 32'h0000_00FF);
    pins(8'hCF, 8'hCF);
    sw(6);
    `CHK(extIrqReq, 1'b0)
    pins(8'hF0, 8'hC0);
    sw(6);
    `CHK({portaAltIn, portbAltIn, timerCaptureOne, timerCaptureTwo}, {8'hF0, 8'hC0, 2'b11})
    bus(1'b0, GPE_PEND_ADDR, 32'h0);
    `CHK({extIrqReq, rdv}, {1'b1, 32'h0000_0003})
    pins(8'hC0, 8'hC0);
    bus(1'b1, GPE_PEND_ADDR, 32'h0000_00FF);
  endtask : t_edges
  task automatic t_outputs();
    bus(1'b1, GPE_PA_DATA_ADDR, 32'h0000_00C0);
    bus(1'b1, GPE_PA_DIR_ADDR, 32'h0000_00FF);
    bus(1'b1, GPE_PA_DATA_ADDR, 32'h0000_0030);
    sw(6);
    `CHK({portaOe, portaOut, extIrqReq}, {8'hFF, 8'h30, 1'b0})
    bus(1'b0, GPE_PA_DATA_ADDR, 32'h0);
    `CHK(rdv, 32'h0000_0030)
    bus(1'b1, GPE_PA_DATA_ADDR, 32'h0000_00C0);
    sw(6);
    bus(1'b1, GPE_PA_DIR_ADDR, 32'h0);
    pins(8'hC5, 8'hC0);
    sw(6);
    bus(1'b0, GPE_PA_DATA_ADDR, 32'h0);
    `CHK(rdv, 32'h0000_00C5)
    bus(1'b0, GPE_PEND_ADDR, 32'h0);
    `CHK(rdv, 32'h0000_0000)
  endtask : t_outputs
  task automatic t_alt();
    @(posedge core_clk);
    portaAltOutEn <= 8'h01; // Pin 0 carries no interrupt line
    portaAltOut <= 8'h01;
    portbAltOutEn <= 8'h01;
    portbAltOut <= 8'h01;
    portbAltOd <= 8'h01;
    sw(3);
    `CHK({portaOe[0], portaOut[0], portbOe[0], portbOut[0]}, 4'b1101)
    @(posedge core_clk);
    portaAltOutEn <= 8'h00;
    portbAltOutEn <= 8'h00;
  endtask : t_alt
  task automatic tally_and_finish();
    if (fails == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {portaAltOutEn, portaAltOut, portaAltOd, portbAltOutEn, portbAltOut, portbAltOd} = '0;
    boardA = 8'hC0;
    boardB = 8'hC0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_mask();
    t_edges();
    t_outputs();
    t_alt();
    tally_and_finish();
  end
  initial begin
    #5_000_000;
    fails++;
    tally_and_finish();
  end
endmodule : tb_gpe_port
bind gpe_port gpe_port_props i_gpe_port_props (
  .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .portaOut(portaOut), .portaOe(portaOe), .portaPullup(portaPullup),
  .portaAltOutEn(portaAltOutEn), .portaAltOut(portaAltOut), .portaAltOd(portaAltOd),
  .portaAltIn(portaAltIn), .timerCaptureOne(timerCaptureOne), .timerCaptureTwo(timerCaptureTwo)
);
